// *** rtl/shared_serial_uart.sv ***
// Shared serial module, UART datapath: Wishbone registers, baud generator,
// transmitter, receiver with a two-character receive store.
// Assumes i_rx and the bus are synchronous to i_clk; the pad logic combines
// o_tx / o_tx_oe_n and the pull-up overrides with the port pull-up control.
`timescale 1ns/1ps
`default_nettype none

module shared_serial_uart #(
    parameter int ADR_W = 5
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [ADR_W-1:0]  i_wb_adr,
    input  wire logic [31:0]       i_wb_dat,
    input  wire logic [3:0]        i_wb_sel,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    input  wire logic              i_rx,
    output logic                   o_tx,
    output logic                   o_tx_oe_n,
    output logic                   o_tx_pu_off,
    output logic                   o_rx_pu_off,
    output logic                   o_irq,
    output logic                   o_wake
);
    initial
    begin
        if (ADR_W < 5)
            $error("ADR_W must be at least 5");
    end

    logic [7:0]  mode_q;
    logic [7:0]  frame_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  baud_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        stat_rd_q;
    logic        uart_mode;
    logic        uart_on;
    logic        req;
    logic        wr;
    logic        rd;
    logic [4:0]  adr;
    logic [7:0]  wdat;
    logic        data_acc;
    logic        clr_err;
    // Baud generator
    logic [7:0]  bcnt_q;
    logic [1:0]  pre_q;
    logic        tick_q;
    // Transmitter
    uart_pkg::line_state_t tx_st_q;
    logic [8:0]  txd_q;
    logic        txif_q;
    logic [8:0]  tsr_q;
    logic [3:0]  ttk_q;
    logic [3:0]  tbit_q;
    logic        tline_q;
    logic        tpar_q;
    logic        tidle;
    logic [3:0]  nbits;
    // Receiver
    uart_pkg::line_state_t rx_st_q;
    logic [3:0]  rtk_q;
    logic [3:0]  rbit_q;
    logic [2:0]  smp_q;
    logic [8:0]  rsr_q;
    logic        rpar_q;
    logic        rnoise_q;
    logic        rmaj;
    logic        rdone;
    logic        rbad_stop;
    logic        rpar_bad;
    logic        rlast;
    logic        rx_prev_q;
    // Receive store
    logic [8:0]  fifo_q [0:1];
    logic        wp_q;
    logic        rp_q;
    logic [1:0]  cnt_q;
    logic        push;
    logic        pop;
    logic        perr_q;
    logic        nf_q;
    logic        ferr_q;
    logic        oerr_q;
    logic        rxif;
    logic [7:0]  stat;

    // Bus decode; one access per request, ack one cycle after the strobe
    assign req       = i_wb_cyc & i_wb_stb & ~ack_q;
    assign wr        = req & i_wb_we & i_wb_sel[0];
    assign rd        = req & ~i_wb_we;
    assign adr       = i_wb_adr[4:0];
    assign wdat      = i_wb_dat[7:0];
    assign uart_mode = mode_q[uart_pkg::MD_UART];
    assign uart_on   = uart_mode & frame_q[uart_pkg::FR_EN];
    assign data_acc  = req & uart_mode & (adr == uart_pkg::ADR_DATA);
    assign clr_err   = data_acc & stat_rd_q;
    assign nbits     = frame_q[uart_pkg::FR_BNO] ? uart_pkg::BITS9 : uart_pkg::BITS8;
    assign tidle     = (tx_st_q == uart_pkg::S_IDLE) & txif_q;
    assign rxif      = (cnt_q != 2'd0);
    assign stat      = {perr_q, nf_q, ferr_q, oerr_q,
                        (rx_st_q == uart_pkg::S_IDLE), rxif, tidle, txif_q};

    // Acknowledge and registered read data
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= req;
            rdat_q <= 32'h0000_0000;
            if (rd)
            begin
                if (adr == uart_pkg::ADR_MODE)
                    rdat_q[7:0] <= mode_q;
                else if (uart_mode)
                begin
                    unique case (adr)
                        uart_pkg::ADR_STAT:  rdat_q[7:0] <= stat;
                        uart_pkg::ADR_FRAME: rdat_q[7:0] <= {frame_q[7:2],
                                                             fifo_q[rp_q][8],
                                                             frame_q[0]};
                        uart_pkg::ADR_CTRL:  rdat_q[7:0] <= ctrl_q;
                        uart_pkg::ADR_DATA:  rdat_q[7:0] <= fifo_q[rp_q][7:0];
                        uart_pkg::ADR_BAUD:  rdat_q[7:0] <= baud_q;
                        default:             rdat_q[7:0] <= uart_pkg::ZERO8;
                    endcase
                end
            end
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // Mode register; sub-mode bits are stored but steer nothing here
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            mode_q <= uart_pkg::MODE_RST;
        else if (wr && adr == uart_pkg::ADR_MODE)
            mode_q <= wdat;
    end

    // Configuration registers, writable only in UART mode
    // disable clears direction enables and break, keeps the rest
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            frame_q <= uart_pkg::ZERO8;
            ctrl_q  <= uart_pkg::ZERO8;
            baud_q  <= uart_pkg::ZERO8;
        end
        else
        begin
            if (wr && uart_mode)
            begin
                if (adr == uart_pkg::ADR_FRAME)
                    frame_q <= {wdat[7:2], 1'b0, wdat[0]};
                if (adr == uart_pkg::ADR_CTRL)
                    ctrl_q <= wdat;
                if (adr == uart_pkg::ADR_BAUD)
                    baud_q <= wdat;
            end
            if (!frame_q[uart_pkg::FR_EN])
            begin
                ctrl_q[uart_pkg::CT_TXEN] <= 1'b0;
                ctrl_q[uart_pkg::CT_RXEN] <= 1'b0;
                frame_q[uart_pkg::FR_BRK] <= 1'b0;
            end
        end
    end

    // Status-read latch arms the error-clear sequence
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            stat_rd_q <= 1'b0;
        else if (rd && uart_mode && adr == uart_pkg::ADR_STAT)
            stat_rd_q <= 1'b1;
        else if (data_acc)
            stat_rd_q <= 1'b0;
    end

    // Oversample tick: divisor+1 clocks, times four more in slow mode
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            bcnt_q <= uart_pkg::ZERO8;
            pre_q  <= 2'd0;
            tick_q <= 1'b0;
        end
        else if (!uart_on)
        begin
            bcnt_q <= uart_pkg::ZERO8;
            pre_q  <= 2'd0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (bcnt_q == baud_q)
            begin
                bcnt_q <= uart_pkg::ZERO8;
                pre_q  <= pre_q + 2'd1;
                tick_q <= ctrl_q[uart_pkg::CT_BRGH] | (pre_q == uart_pkg::SLOW_LAST);
            end
            else
                bcnt_q <= bcnt_q + 8'd1;
        end
    end

    // Transmit holding register and empty flag; a load and a new write
    // in one cycle keep the new byte pending
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            txd_q  <= 9'h000;
            txif_q <= 1'b1;
        end
        else if (!uart_on)
            txif_q <= 1'b1;
        else
        begin
            if (!txif_q && tx_st_q == uart_pkg::S_IDLE && ctrl_q[uart_pkg::CT_TXEN])
                txif_q <= 1'b1;
            if (wr && data_acc)
            begin
                txd_q  <= {frame_q[uart_pkg::FR_TX8], wdat};
                txif_q <= 1'b0;
            end
        end
    end

    // Transmit shifter: start, data LSB first, optional parity, stops
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_st_q <= uart_pkg::S_IDLE;
            tsr_q   <= 9'h000;
            ttk_q   <= 4'd0;
            tbit_q  <= 4'd0;
            tline_q <= 1'b1;
            tpar_q  <= 1'b0;
        end
        else if (!uart_on)
        begin
            tx_st_q <= uart_pkg::S_IDLE;
            tline_q <= 1'b1;
        end
        else
        begin
            unique case (tx_st_q)
                uart_pkg::S_IDLE:
                begin
                    tline_q <= 1'b1;
                    if (!txif_q && ctrl_q[uart_pkg::CT_TXEN])
                    begin
                        tsr_q   <= txd_q;
                        ttk_q   <= 4'd0;
                        tbit_q  <= 4'd0;
                        tpar_q  <= frame_q[uart_pkg::FR_PRT];
                        tline_q <= 1'b0;
                        tx_st_q <= uart_pkg::S_START;
                    end
                end
                uart_pkg::S_START, uart_pkg::S_DATA, uart_pkg::S_PAR, uart_pkg::S_STOP:
                begin
                    if (tick_q)
                    begin
                        ttk_q <= ttk_q + 4'd1;
                        if (ttk_q == uart_pkg::TICK_LAST)
                        begin
                            tbit_q <= tbit_q + 4'd1;
                            unique case (tx_st_q)
                                uart_pkg::S_START:
                                begin
                                    tbit_q  <= 4'd0;
                                    tline_q <= tsr_q[0];
                                    tx_st_q <= uart_pkg::S_DATA;
                                end
                                uart_pkg::S_DATA:
                                begin
                                    tpar_q <= tpar_q ^ tsr_q[tbit_q];
                                    if (tbit_q == nbits - 4'd1)
                                    begin
                                        tbit_q <= 4'd0;
                                        if (frame_q[uart_pkg::FR_PREN])
                                        begin
                                            tline_q <= tpar_q ^ tsr_q[tbit_q];
                                            tx_st_q <= uart_pkg::S_PAR;
                                        end
                                        else
                                        begin
                                            tline_q <= 1'b1;
                                            tx_st_q <= uart_pkg::S_STOP;
                                        end
                                    end
                                    else
                                        tline_q <= tsr_q[tbit_q + 4'd1];
                                end
                                uart_pkg::S_PAR:
                                begin
                                    tbit_q  <= 4'd0;
                                    tline_q <= 1'b1;
                                    tx_st_q <= uart_pkg::S_STOP;
                                end
                                default:
                                begin
                                    if (tbit_q != 4'd0 || !frame_q[uart_pkg::FR_STOPS])
                                        tx_st_q <= uart_pkg::S_IDLE;
                                end
                            endcase
                        end
                    end
                end
                default: tx_st_q <= uart_pkg::S_IDLE;
            endcase
        end
    end

    // Receive sampling: three centre samples, majority decides
    assign rmaj = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
    assign rdone = tick_q & (rtk_q == uart_pkg::TICK_LAST) & (rx_st_q == uart_pkg::S_STOP);
    assign rbad_stop = ~rmaj;
    assign rpar_bad = frame_q[uart_pkg::FR_PREN] & rpar_q;
    assign rlast = frame_q[uart_pkg::FR_BNO] ? rsr_q[8] : rsr_q[7];

    // Receiver state machine
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rx_st_q  <= uart_pkg::S_IDLE;
            rtk_q    <= 4'd0;
            rbit_q   <= 4'd0;
            smp_q    <= 3'b111;
            rsr_q    <= 9'h000;
            rpar_q   <= 1'b0;
            rnoise_q <= 1'b0;
        end
        else if (!uart_on || !ctrl_q[uart_pkg::CT_RXEN])
            rx_st_q <= uart_pkg::S_IDLE;
        else if (tick_q)
        begin
            rtk_q <= rtk_q + 4'd1;
            if (rtk_q >= uart_pkg::SMP_A && rtk_q <= uart_pkg::SMP_C)
                smp_q <= {smp_q[1:0], i_rx};
            unique case (rx_st_q)
                uart_pkg::S_IDLE:
                begin
                    // low line on a tick marks a start bit
                    rtk_q <= 4'd0;
                    if (!i_rx)
                    begin
                        rx_st_q  <= uart_pkg::S_START;
                        rbit_q   <= 4'd0;
                        rnoise_q <= 1'b0;
                        rpar_q   <= frame_q[uart_pkg::FR_PRT];
                        rtk_q    <= 4'd1;
                    end
                end
                default:
                begin
                    if (rtk_q == uart_pkg::TICK_LAST)
                    begin
                        if (smp_q != 3'b000 && smp_q != 3'b111)
                            rnoise_q <= 1'b1;
                        unique case (rx_st_q)
                            uart_pkg::S_START:
                                rx_st_q <= rmaj ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
                            uart_pkg::S_DATA:
                            begin
                                rsr_q[rbit_q] <= rmaj;
                                rpar_q <= rpar_q ^ rmaj;
                                rbit_q <= rbit_q + 4'd1;
                                if (!frame_q[uart_pkg::FR_BNO])
                                    rsr_q[8] <= 1'b0;
                                if (rbit_q == nbits - 4'd1)
                                    rx_st_q <= frame_q[uart_pkg::FR_PREN] ?
                                               uart_pkg::S_PAR : uart_pkg::S_STOP;
                            end
                            uart_pkg::S_PAR:
                            begin
                                // odd count of ones with seed marks a mismatch
                                rpar_q  <= rpar_q ^ rmaj;
                                rx_st_q <= uart_pkg::S_STOP;
                            end
                            default: rx_st_q <= uart_pkg::S_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // Receive store: push completed characters, pop on data read
    assign push = rdone & ~oerr_q & (cnt_q != 2'd2)
                  & (~ctrl_q[uart_pkg::CT_ADDEN] | rlast);
    assign pop  = rd & data_acc & rxif;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            fifo_q[0] <= 9'h000;
            fifo_q[1] <= 9'h000;
            wp_q      <= 1'b0;
            rp_q      <= 1'b0;
            cnt_q     <= 2'd0;
        end
        else if (!uart_on)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                fifo_q[wp_q] <= rsr_q;
                wp_q <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Error flags; a new error wins over the clear sequence
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            perr_q <= 1'b0;
            nf_q   <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
        end
        else if (!uart_on)
        begin
            perr_q <= 1'b0;
            nf_q   <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
        end
        else
        begin
            if (clr_err)
            begin
                perr_q <= 1'b0;
                nf_q   <= 1'b0;
                ferr_q <= 1'b0;
                oerr_q <= 1'b0;
            end
            if (rdone && (cnt_q == 2'd2 || oerr_q))
                oerr_q <= 1'b1;
            if (push)
            begin
                perr_q <= perr_q | rpar_bad;
                nf_q   <= nf_q | rnoise_q;
                ferr_q <= ferr_q | rbad_stop;
            end
        end
    end

    // Pin control, interrupt and wake-up, all registered
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_tx        <= 1'b1;
            o_tx_oe_n   <= 1'b1;
            o_tx_pu_off <= 1'b0;
            o_rx_pu_off <= 1'b0;
            o_irq       <= 1'b0;
            o_wake      <= 1'b0;
            rx_prev_q   <= 1'b1;
        end
        else
        begin
            o_tx_oe_n   <= ~(uart_on & ctrl_q[uart_pkg::CT_TXEN]);
            o_tx_pu_off <= uart_on & ctrl_q[uart_pkg::CT_TXEN];
            o_rx_pu_off <= uart_on & ctrl_q[uart_pkg::CT_RXEN];
            o_tx        <= tline_q & ~frame_q[uart_pkg::FR_BRK];
            o_irq       <= uart_on & ((ctrl_q[uart_pkg::CT_RIE] & (rxif | oerr_q))
                           | (ctrl_q[uart_pkg::CT_TIIE] & tidle)
                           | (ctrl_q[uart_pkg::CT_TEIE] & txif_q));
            rx_prev_q   <= i_rx;
            o_wake      <= uart_on & ctrl_q[uart_pkg::CT_WAKE] & rx_prev_q & ~i_rx
                           & (rx_st_q == uart_pkg::S_IDLE);
        end
    end

endmodule // shared_serial_uart

`default_nettype wire

// *** rtl/uart_pkg.sv ***
// Shared constants for the shared-serial UART datapath.
// Assumes 8-bit registers placed one per aligned 32-bit Wishbone word.
package uart_pkg;
    // Register byte addresses
    localparam logic [4:0] ADR_MODE  = 5'h00;
    localparam logic [4:0] ADR_STAT  = 5'h04;
    localparam logic [4:0] ADR_FRAME = 5'h08;
    localparam logic [4:0] ADR_CTRL  = 5'h0c;
    localparam logic [4:0] ADR_DATA  = 5'h10;
    localparam logic [4:0] ADR_BAUD  = 5'h14;
    // Reset values
    localparam logic [7:0] MODE_RST  = 8'he0;
    localparam logic [7:0] ZERO8     = 8'h00;
    // serial_module_mode_control fields
    localparam int MD_UART  = 4;
    // uart_frame_control fields
    localparam int FR_EN    = 7;
    localparam int FR_BNO   = 6;
    localparam int FR_PREN  = 5;
    localparam int FR_PRT   = 4;
    localparam int FR_STOPS = 3;
    localparam int FR_BRK   = 2;
    localparam int FR_RX8   = 1;
    localparam int FR_TX8   = 0;
    // uart_enable_interrupt_control fields
    localparam int CT_TXEN  = 7;
    localparam int CT_RXEN  = 6;
    localparam int CT_BRGH  = 5;
    localparam int CT_ADDEN = 4;
    localparam int CT_WAKE  = 3;
    localparam int CT_RIE   = 2;
    localparam int CT_TIIE  = 1;
    localparam int CT_TEIE  = 0;
    // Oversampling: ticks per bit, sample points, slow-rate prescale
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] SMP_A     = 4'h7;
    localparam logic [3:0] SMP_C     = 4'h9;
    localparam logic [1:0] SLOW_LAST = 2'h3;
    localparam logic [3:0] BITS8     = 4'h8;
    localparam logic [3:0] BITS9     = 4'h9;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_START = 3'b001,
        S_DATA  = 3'b010,
        S_PAR   = 3'b011,
        S_STOP  = 3'b100
    } line_state_t;
endpackage

// *** testbench/serial_peer.sv ***
// Far-side serial device: sends frames on its line, decodes the UART output.
// Assumes BIT_CLKS system clocks per bit and eight data bits.
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic i_clk,
    input  wire logic i_line,
    output var logic  o_line
);
    initial o_line = 1'b1;
    task automatic send(input logic [7:0] d, input logic pe, input logic pb);
        logic [10:0] f;
        f = {1'b1, pb, d, 1'b0};
        for (int i = 0; i < 11; i++)
            if (i != 9 || pe)
            begin
                @(posedge i_clk);
                o_line <= f[i];
                repeat (BIT_CLKS - 1) @(posedge i_clk);
            end
    endtask
    // Mid-bit sampling tolerates small edge skew
    task automatic get(output logic [7:0] d);
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge i_clk);
            d[i] = i_line;
        end
    endtask
endmodule // serial_peer
`default_nettype wire

// *** testbench/tb_shared_serial_uart.sv ***
// Testbench for the shared serial UART: bus tasks, serial peer, scenarios.
// Assumes package, design, checker and peer are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_shared_serial_uart;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tx, rx;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0]  q, g;
    logic        oen, rxpu, irq, wake;
    int          wakes = 0;
    int          err_count = 0, checked = 0;
    // 10 MHz system clock
    always #50 clk = ~clk;
    shared_serial_uart shared_serial_uart_inst (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'h1),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx(rx), .o_tx(tx), .o_tx_oe_n(oen),
        .o_tx_pu_off(), .o_rx_pu_off(rxpu), .o_irq(irq), .o_wake(wake));
    serial_peer serial_peer_inst (.i_clk(clk), .i_line(tx), .o_line(rx));
    // Wake pulses last one cycle, so count them as they pass
    always @(posedge clk)
        if (wake === 1'b1)
            wakes <= wakes + 1;
    task automatic close_out();
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
        checked++;
        if (v !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, v);
        end
    endtask
    // Classic cycle held until ack is sampled; one idle cycle follows
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string s);
        wb(1'b0, a, 8'h00);
        chk(s, e, q);
    endtask
    // Hang guard, far above the fewer than two thousand cycles needed
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(uart_pkg::ADR_MODE, uart_pkg::MODE_RST, "mode reset");
        rd(uart_pkg::ADR_DATA, 8'h00, "data other mode");
        wb(1'b1, uart_pkg::ADR_MODE, 8'hf0);
        wb(1'b1, uart_pkg::ADR_BAUD, 8'h00);
        // Direction enables are held clear while the UART is off: switch it on first
        wb(1'b1, uart_pkg::ADR_FRAME, 8'h80);
        wb(1'b1, uart_pkg::ADR_CTRL, 8'hec);
        rd(5'h18, 8'h00, "unmapped");
        chk("tx drive", 8'h00, {7'h00, oen});
        chk("rx pull off", 8'h01, {7'h00, rxpu});
        fork
            serial_peer_inst.get(g);
            wb(1'b1, uart_pkg::ADR_DATA, 8'ha5);
        join
        chk("tx byte", 8'ha5, g);
        // Third character meets a full store
        serial_peer_inst.send(8'h3c, 1'b0, 1'b0);
        serial_peer_inst.send(8'h5a, 1'b0, 1'b0);
        serial_peer_inst.send(8'h77, 1'b0, 1'b0);
        repeat (16) @(posedge clk);
        rd(uart_pkg::ADR_STAT, 8'h1f, "status overrun");
        chk("irq pending", 8'h01, {7'h00, irq});
        rd(uart_pkg::ADR_DATA, 8'h3c, "rx first");
        rd(uart_pkg::ADR_DATA, 8'h5a, "rx second");
        rd(uart_pkg::ADR_STAT, 8'h0b, "status drained");
        chk("irq quiet", 8'h00, {7'h00, irq});
        // Even then odd parity, same parity bit
        for (int i = 0; i < 2; i++)
        begin
            wb(1'b1, uart_pkg::ADR_FRAME, {3'b101, i[0], 4'h0});
            serial_peer_inst.send(8'h01, 1'b1, 1'b0);
            repeat (16) @(posedge clk);
            rd(uart_pkg::ADR_STAT, i[0] ? 8'h0f : 8'h8f, "status parity");
            rd(uart_pkg::ADR_DATA, 8'h01, "rx parity");
        end
        // Address detect keeps only characters whose last data bit is one
        wb(1'b1, uart_pkg::ADR_FRAME, 8'h80);
        wb(1'b1, uart_pkg::ADR_CTRL, 8'hfc);
        serial_peer_inst.send(8'h01, 1'b0, 1'b0);
        serial_peer_inst.send(8'h81, 1'b0, 1'b0);
        repeat (16) @(posedge clk);
        rd(uart_pkg::ADR_DATA, 8'h81, "rx address");
        rd(uart_pkg::ADR_STAT, 8'h0b, "status address");
        wb(1'b1, uart_pkg::ADR_FRAME, 8'h00);
        rd(uart_pkg::ADR_CTRL, 8'h3c, "ctrl disabled");
        chk("tx released", 8'h01, {7'h00, oen});
        chk("rx pull kept", 8'h00, {7'h00, rxpu});
        chk("wake count", 8'h07, wakes[7:0]);
        close_out();
    end
endmodule // tb_shared_serial_uart
`default_nettype wire

// *** testbench/uart_asserts.sv ***
// Checker on the UART top-level ports, bound into the design.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module uart_checker (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_tx,
    input wire logic        o_tx_oe_n,
    input wire logic        o_tx_pu_off,
    input wire logic        o_wake
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Bus answers a fresh request once, one cycle later
    a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
    a_ack_none: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("stray ack");
    a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("upper lanes set");
    // Pin drive and pull-up override move together
    a_pull_tie: assert property (o_tx_pu_off != o_tx_oe_n) else $error("pull mismatch");
    a_oe_idle: assert property ($fell(o_tx_oe_n) |-> o_tx) else $error("drive not idle");
    // A driven start bit stays low for its first clock and at least eight more
    a_start_low: assert property ($fell(o_tx) && !o_tx_oe_n |=> !o_tx [*8])
        else $error("short start");
    a_wake_pulse: assert property (o_wake |=> !o_wake) else $error("long wake");
    cover property (o_wb_ack);
    cover property ($fell(o_tx));
    cover property (o_wake);
endmodule // uart_checker
bind shared_serial_uart uart_checker uart_checker_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_tx(o_tx), .o_tx_oe_n(o_tx_oe_n), .o_tx_pu_off(o_tx_pu_off), .o_wake(o_wake));
`default_nettype wire
